// *** hw/cms_defs.svh ***
// Register offsets, field positions and reset values of the CAN status slice
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ============================================================
// Register map (byte offsets, low address bits)
`define CMS_ADDR_W          8
`define CMS_OFS_TX_STATUS   8'h08
`define CMS_OFS_RX_FIFO0    8'h0C
`define CMS_OFS_RX_FIFO1    8'h10
`define CMS_OFS_IRQ_ENABLE  8'h14
`define CMS_OFS_CORE_STATUS 8'h18

// ============================================================
// Transmit status fields, per-mailbox fields at 8 * mailbox
`define CMS_MBX_STRIDE      8
`define CMS_TX_DONE         0
`define CMS_TX_OK           1
`define CMS_TX_ALOST        2
`define CMS_TX_FAIL         3
`define CMS_TX_ABORT        7
`define CMS_TX_CODE         24
`define CMS_TX_EMPTY        26
`define CMS_TX_LOW          29
`define CMS_TX_EMPTY_RST    3'b111

// ============================================================
// Receive FIFO status fields
`define CMS_RX_COUNT        0
`define CMS_RX_FULL         3
`define CMS_RX_OVR          4
`define CMS_RX_REL          5

// ============================================================
// Interrupt enable fields
`define CMS_IE_SLEEP        17
`define CMS_IE_WAKE         16
`define CMS_IE_ERR          15
`define CMS_IE_LEC          11
`define CMS_IE_BOFF         10
`define CMS_IE_RW_MASK      32'h0003_8F7F

// ============================================================
// Core status and control fields
`define CMS_CS_INIT_MODE_ACK         0
`define CMS_CS_ERROR_EVENT_FLAG         2
`define CMS_CS_LEC          4
`define CMS_CS_TX_ORDER_PRIORITY_SELECT         8

// ============================================================
// Bus encodings
`define CMS_HTRANS_NSEQ_BIT 1
`define CMS_HRESP_OKAY      1'b0

`endif

// *** hw/cms_pkg.sv ***
// Types shared by the CAN status slice
package cms_pkg;

    // Fault codes of the last-fault field
    typedef enum logic [2:0] {
        CMS_FAULT_NONE   = 3'h0,
        CMS_FAULT_STUFF  = 3'h1,
        CMS_FAULT_FORM   = 3'h2,
        CMS_FAULT_ACK    = 3'h3,
        CMS_FAULT_REC    = 3'h4,
        CMS_FAULT_DOM    = 3'h5,
        CMS_FAULT_CRC    = 3'h6,
        CMS_FAULT_SW     = 3'h7
    } cms_fault_e;

    typedef logic [1:0] cms_count_t;

endpackage

// *** hw/cms_status.sv ***
// CAN mailbox, receive FIFO status and interrupt enable slice with AHB-Lite slave
// Functional notes
// - Mailbox empty flags, reset to one
// - Read-only lowest-priority flag per mailbox
// - Code field names lowest-priority mailbox
// - Abort bit set by one, hardware clears
// - Failure flag set by hardware, write-one clears
// - Arbitration-lost flag, write-one clears
// - Success flag reflects last send result
// - Request-done flag on send or abort completion
// - Release bit drops head message, self-clears
// - Overrun flag when arrival hits full FIFO
// - Full flag when FIFO holds three
// - Two-bit pending count, resets to zero
// - Second independent FIFO at own offset
// - Sleep interrupt gated by its enable
// - Wake interrupt gated by its enable
// - Master enable gates error interrupt
// - Fault code always updates, event gated
// - Init acknowledge low outside init mode
// - Fault codes, software seven, clean clears
// - Priority by identifier or request order
// - Bus-off sets error event when enabled
// - Error event flag, write-one clears
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cms_defs.svh"

module cms_status #(
    parameter int MSG_W = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [2:0]       tx_request,
    input  wire logic [2:0]       tx_done_ok,
    input  wire logic [2:0]       tx_done_fail,
    input  wire logic [2:0]       tx_arb_lost,
    input  wire logic [2:0]       tx_abort_ack,
    input  wire logic [28:0]      tx_ident_0,
    input  wire logic [28:0]      tx_ident_1,
    input  wire logic [28:0]      tx_ident_2,
    output logic      [2:0]       tx_abort_req,
    input  wire logic [1:0]       rx_arrive,
    input  wire logic [MSG_W-1:0] rx_msg_0,
    input  wire logic [MSG_W-1:0] rx_msg_1,
    output logic      [MSG_W-1:0] rx_head_0,
    output logic      [MSG_W-1:0] rx_head_1,
    input  wire logic             err_detect,
    input  wire logic [2:0]       err_code,
    input  wire logic             xfer_clean,
    input  wire logic             bus_off_enter,
    input  wire logic             sleep_enter,
    input  wire logic             wake_event,
    input  wire logic             init_mode_active,
    output logic                  err_irq,
    output logic                  sleep_irq,
    output logic                  wake_irq
);

    // ============================================================
    // Parameter check
    if (MSG_W < 1) begin : g_bad_width
        $error("MSG_W must be at least one");
    end

    // ============================================================
    // Bus slave state
    logic                  dp_write;
    logic                  next_dp_write;
    logic [`CMS_ADDR_W-1:0] dp_addr;
    logic [`CMS_ADDR_W-1:0] next_dp_addr;
    logic [31:0]           next_hrdata;
    logic                  ap_take;
    logic                  wr_tx;
    logic                  wr_rx0;
    logic                  wr_rx1;
    logic                  wr_ie;
    logic                  wr_cs;

    // Mailbox state
    logic [2:0]            empty;
    logic [2:0]            next_empty;
    logic [2:0]            abort;
    logic [2:0]            next_abort;
    logic [2:0]            fail;
    logic [2:0]            next_fail;
    logic [2:0]            alost;
    logic [2:0]            next_alost;
    logic [2:0]            okflag;
    logic [2:0]            next_okflag;
    logic [2:0]            done;
    logic [2:0]            next_done;
    logic [1:0]            rank [3];
    logic [1:0]            next_rank [3];
    logic [1:0]            code;
    logic [1:0]            next_code;
    logic [2:0]            low;
    logic [28:0]           ident [3];

    // Receive FIFO state
    cms_pkg::cms_count_t   rx_cnt [2];
    cms_pkg::cms_count_t   next_rx_cnt [2];
    logic [1:0]            rx_full;
    logic [1:0]            next_rx_full;
    logic [1:0]            rx_ovr;
    logic [1:0]            next_rx_ovr;
    logic [1:0]            rx_rel;
    logic [1:0]            next_rx_rel;
    logic [MSG_W-1:0]      rx_mem [2][3];
    logic [MSG_W-1:0]      next_rx_mem [2][3];
    logic [MSG_W-1:0]      rx_in [2];
    logic [1:0]            wr_rx;

    // Error and enable state
    logic [31:0]           ien;
    logic [31:0]           next_ien;
    logic                  error_event_flag;
    logic                  next_error_event_flag;
    logic [2:0]            last_fault_code;
    logic [2:0]            next_lec;
    logic                  tx_order_priority_select;
    logic                  next_tx_order_priority_select;
    logic                  init_mode_ack;
    logic                  next_init_mode_ack;

    // ============================================================
    // Bus decode
    assign ap_take   = hsel && hready && htrans[`CMS_HTRANS_NSEQ_BIT];
    assign hreadyout = 1'b1;
    assign hresp     = `CMS_HRESP_OKAY;
    assign wr_tx     = dp_write && (dp_addr == `CMS_OFS_TX_STATUS);
    assign wr_rx0    = dp_write && (dp_addr == `CMS_OFS_RX_FIFO0);
    assign wr_rx1    = dp_write && (dp_addr == `CMS_OFS_RX_FIFO1);
    assign wr_ie     = dp_write && (dp_addr == `CMS_OFS_IRQ_ENABLE);
    assign wr_cs     = dp_write && (dp_addr == `CMS_OFS_CORE_STATUS);
    assign wr_rx     = {wr_rx1, wr_rx0};
    assign ident[0]  = tx_ident_0;
    assign ident[1]  = tx_ident_1;
    assign ident[2]  = tx_ident_2;
    assign rx_in[0]  = rx_msg_0;
    assign rx_in[1]  = rx_msg_1;

    // Address phase capture and read data from next-state values, except code, empty, low and init_mode_ack
    always_comb begin
        next_dp_write = ap_take && hwrite;
        next_dp_addr  = haddr[`CMS_ADDR_W-1:0];
        next_hrdata   = hrdata;
        if (ap_take && !hwrite) begin
            next_hrdata = 32'h0000_0000;  // Unmapped and reserved read zero
            case (haddr[`CMS_ADDR_W-1:0])
                `CMS_OFS_TX_STATUS: begin
                    for (int i = 0; i < 3; i++) begin
                        next_hrdata[i*`CMS_MBX_STRIDE + `CMS_TX_DONE]  = next_done[i];
                        next_hrdata[i*`CMS_MBX_STRIDE + `CMS_TX_OK]    = next_okflag[i];
                        next_hrdata[i*`CMS_MBX_STRIDE + `CMS_TX_ALOST] = next_alost[i];
                        next_hrdata[i*`CMS_MBX_STRIDE + `CMS_TX_FAIL]  = next_fail[i];
                        next_hrdata[i*`CMS_MBX_STRIDE + `CMS_TX_ABORT] = next_abort[i];
                    end
                    next_hrdata[`CMS_TX_CODE +: 2]  = code;
                    next_hrdata[`CMS_TX_EMPTY +: 3] = empty;
                    next_hrdata[`CMS_TX_LOW +: 3]   = low;
                end
                `CMS_OFS_RX_FIFO0, `CMS_OFS_RX_FIFO1: begin
                    for (int f = 0; f < 2; f++) begin
                        if (haddr[`CMS_ADDR_W-1:0] == (f == 0 ? `CMS_OFS_RX_FIFO0
                                                              : `CMS_OFS_RX_FIFO1)) begin
                            next_hrdata[`CMS_RX_COUNT +: 2] = next_rx_cnt[f];
                            next_hrdata[`CMS_RX_FULL]       = next_rx_full[f];
                            next_hrdata[`CMS_RX_OVR]        = next_rx_ovr[f];
                            next_hrdata[`CMS_RX_REL]        = next_rx_rel[f];
                        end
                    end
                end
                `CMS_OFS_IRQ_ENABLE: begin
                    next_hrdata = next_ien;
                end
                `CMS_OFS_CORE_STATUS: begin
                    next_hrdata[`CMS_CS_INIT_MODE_ACK]     = init_mode_ack;
                    next_hrdata[`CMS_CS_ERROR_EVENT_FLAG]     = next_error_event_flag;
                    next_hrdata[`CMS_CS_LEC +: 3] = next_lec;
                    next_hrdata[`CMS_CS_TX_ORDER_PRIORITY_SELECT]     = next_tx_order_priority_select;
                end
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
            hrdata   <= 32'h0000_0000;
        end else if (clk_en) begin
            dp_write <= next_dp_write;
            dp_addr  <= next_dp_addr;
            hrdata   <= next_hrdata;
        end
    end

    // ============================================================
    // Mailbox flags, ranks and lowest-priority pick
    always_comb begin
        logic [2:0] pend;
        logic [2:0] leave;
        logic [2:0] clr;
        logic [1:0] best;
        logic       have;
        logic [1:0] cnt;
        pend  = ~empty;
        leave = (tx_done_ok | tx_done_fail | tx_abort_ack) & pend;
        best  = 2'd0;
        have  = 1'b0;
        cnt   = 2'h0;
        for (int i = 0; i < 3; i++) begin
            clr[i] = wr_tx && hwdata[i*`CMS_MBX_STRIDE + `CMS_TX_OK];
            next_empty[i] = (empty[i] && !tx_request[i]) || leave[i];
            next_abort[i] = (abort[i] || (wr_tx && pend[i]
                            && hwdata[i*`CMS_MBX_STRIDE + `CMS_TX_ABORT]))
                            && !leave[i] && !empty[i];
            next_fail[i]  = (fail[i] && !(wr_tx
                            && hwdata[i*`CMS_MBX_STRIDE + `CMS_TX_FAIL]))
                            || tx_done_fail[i];
            next_alost[i] = (alost[i] && !(wr_tx
                            && hwdata[i*`CMS_MBX_STRIDE + `CMS_TX_ALOST]))
                            || tx_arb_lost[i];
            if (tx_done_ok[i]) begin
                next_okflag[i] = 1'b1;
            end else if (tx_done_fail[i]) begin
                next_okflag[i] = 1'b0;
            end else begin
                next_okflag[i] = okflag[i] && !clr[i];
            end
            next_done[i]  = (done[i] && !(wr_tx
                            && hwdata[i*`CMS_MBX_STRIDE + `CMS_TX_DONE]))
                            || tx_done_ok[i] || tx_done_fail[i]
                            || tx_abort_ack[i];
        end
        // Request order: rank counts older pending mailboxes
        for (int i = 0; i < 3; i++) begin
            cnt = rank[i];
            for (int j = 0; j < 3; j++) begin
                if (leave[j] && rank[j] < rank[i]) begin
                    cnt = cnt - 2'd1;
                end
            end
            if (tx_request[i] && empty[i]) begin
                cnt = 2'd0;
                for (int j = 0; j < 3; j++) begin
                    if (j != i && ((pend[j] && !leave[j])
                        || (tx_request[j] && empty[j] && j < i))) begin
                        cnt = cnt + 2'd1;
                    end
                end
            end
            next_rank[i] = cnt;
        end
        // Lowest priority: largest identifier or newest request
        for (int i = 0; i < 3; i++) begin
            if (pend[i] && (!have || (tx_order_priority_select ? rank[i] >= rank[best]
                                           : ident[i] >= ident[best]))) begin
                best = 2'(i);
                have = 1'b1;
            end
        end
        low = have ? (3'b001 << best) : 3'b000;
        next_code = have ? best : code;
    end

    // Mailbox registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            empty  <= `CMS_TX_EMPTY_RST;
            abort  <= 3'h0;
            fail   <= 3'h0;
            alost  <= 3'h0;
            okflag <= 3'h0;
            done   <= 3'h0;
            code   <= 2'h0;
            rank   <= '{default: 2'h0};
        end else if (clk_en) begin
            empty  <= next_empty;
            abort  <= next_abort;
            fail   <= next_fail;
            alost  <= next_alost;
            okflag <= next_okflag;
            done   <= next_done;
            code   <= next_code;
            rank   <= next_rank;
        end
    end

    assign tx_abort_req = abort;

    // ============================================================
    // Receive FIFOs: head in slot zero, shift on release
    always_comb begin
        logic                pop;
        logic                push;
        cms_pkg::cms_count_t base;
        pop  = 1'b0;
        push = 1'b0;
        base = 2'h0;
        for (int f = 0; f < 2; f++) begin
            pop  = rx_rel[f] && (rx_cnt[f] != 2'd0);
            base = pop ? rx_cnt[f] - 2'd1 : rx_cnt[f];
            push = rx_arrive[f] && (base != 2'd3);
            for (int k = 0; k < 3; k++) begin
                next_rx_mem[f][k] = (pop && k < 2) ? rx_mem[f][k+1] : rx_mem[f][k];
            end
            if (push) begin
                next_rx_mem[f][base] = rx_in[f];
            end
            next_rx_cnt[f]  = push ? base + 2'd1 : base;
            next_rx_rel[f]  = wr_rx[f] && hwdata[`CMS_RX_REL];
            next_rx_ovr[f]  = (rx_ovr[f] && !(wr_rx[f] && hwdata[`CMS_RX_OVR]))
                              || (rx_arrive[f] && !push);
            next_rx_full[f] = (rx_full[f] && !(wr_rx[f] && hwdata[`CMS_RX_FULL]))
                              || (push && base == 2'd2);
        end
    end

    // Receive FIFO registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full <= 2'h0;
            rx_ovr  <= 2'h0;
            rx_rel  <= 2'h0;
            for (int f = 0; f < 2; f++) begin
                rx_cnt[f] <= 2'h0;
                for (int k = 0; k < 3; k++) begin
                    rx_mem[f][k] <= '0;
                end
            end
        end else if (clk_en) begin
            rx_full <= next_rx_full;
            rx_ovr  <= next_rx_ovr;
            rx_rel  <= next_rx_rel;
            rx_cnt  <= next_rx_cnt;
            rx_mem  <= next_rx_mem;
        end
    end

    assign rx_head_0 = rx_mem[0][0];
    assign rx_head_1 = rx_mem[1][0];

    // ============================================================
    // Enables, fault code and error event
    always_comb begin
        next_ien  = wr_ie ? (hwdata & `CMS_IE_RW_MASK) : ien;
        next_tx_order_priority_select = wr_cs ? hwdata[`CMS_CS_TX_ORDER_PRIORITY_SELECT] : tx_order_priority_select;
        next_init_mode_ack = init_mode_active;
        next_lec  = last_fault_code;
        if (wr_cs) begin
            next_lec = hwdata[`CMS_CS_LEC +: 3];
        end
        if (err_detect) begin
            next_lec = err_code;
        end else if (xfer_clean) begin
            next_lec = cms_pkg::CMS_FAULT_NONE;
        end
        next_error_event_flag = (error_event_flag && !(wr_cs && hwdata[`CMS_CS_ERROR_EVENT_FLAG]))
                    || (err_detect && ien[`CMS_IE_LEC])
                    || (bus_off_enter && ien[`CMS_IE_BOFF]);
    end

    // Enable and error registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ien  <= 32'h0000_0000;
            tx_order_priority_select <= 1'b0;
            init_mode_ack <= 1'b0;
            last_fault_code  <= cms_pkg::CMS_FAULT_NONE;
            error_event_flag <= 1'b0;
        end else if (clk_en) begin
            ien  <= next_ien;
            tx_order_priority_select <= next_tx_order_priority_select;
            init_mode_ack <= next_init_mode_ack;
            last_fault_code  <= next_lec;
            error_event_flag <= next_error_event_flag;
        end
    end

    // Interrupt outputs
    assign err_irq   = error_event_flag && ien[`CMS_IE_ERR];
    assign sleep_irq = clk_en && sleep_enter && ien[`CMS_IE_SLEEP];
    assign wake_irq  = clk_en && wake_event && ien[`CMS_IE_WAKE];

endmodule // cms_status

// *** test/cms_status_props.sv ***
// Concurrent checks on the CAN status slice ports
`timescale 1ns/1ps
module cms_status_props #(
    parameter int MSG_W = 8
) (
    input logic             mclk,
    input logic             rst_n,
    input logic             clk_en,
    input logic             hsel,
    input logic [1:0]       htrans,
    input logic             hwrite,
    input logic             hready,
    input logic [2:0]       tx_done_ok,
    input logic [2:0]       tx_done_fail,
    input logic [2:0]       tx_abort_ack,
    input logic [2:0]       tx_abort_req,
    input logic [1:0]       rx_arrive,
    input logic [MSG_W-1:0] rx_head_0,
    input logic             err_detect,
    input logic             bus_off_enter,
    input logic             sleep_enter,
    input logic             wake_event,
    input logic             err_irq,
    input logic             sleep_irq,
    input logic             wake_irq
);
    // ============================================================
    // Helpers
    wire wr = hsel && hready && htrans[1] && hwrite && clk_en;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_ack_taken;
        tx_abort_req[1] && tx_abort_ack[1] && clk_en;
    endsequence
    property p_abort_drop;
        s_ack_taken |=> !tx_abort_req[1];
    endproperty
    // ============================================================
    // Assertions
    a_sleep_gate: assert property (sleep_irq |-> sleep_enter && clk_en)
        else $error("sleep interrupt without event");
    a_wake_gate: assert property (wake_irq |-> wake_event && clk_en)
        else $error("wake interrupt without event");
    a_abort_drop: assert property (p_abort_drop)
        else $error("abort request kept after drop");
    a_abort_hold: assert property (tx_abort_req[1] && clk_en
        && !(tx_abort_ack[1] || tx_done_ok[1] || tx_done_fail[1]) |=> tx_abort_req[1])
        else $error("abort request lost early");
    a_abort_origin: assert property ($rose(tx_abort_req[1]) |-> $past(wr, 2))
        else $error("abort request without write");
    a_err_rise: assert property ($rose(err_irq)
        |-> $past(err_detect || bus_off_enter) || $past(wr, 2))
        else $error("error interrupt without cause");
    a_err_fall: assert property ($fell(err_irq) |-> $past(wr, 2))
        else $error("error interrupt dropped without write");
    a_head_move: assert property (!$stable(rx_head_0)
        |-> $past(rx_arrive[0]) || $past(wr, 3))
        else $error("head message moved without cause");
endmodule // cms_status_props

bind cms_status cms_status_props #(.MSG_W(MSG_W)) u_props (.*);

// *** test/cms_engine_model.sv ***
// Behavioural transmit engine that answers abort requests
`timescale 1ns/1ps
module cms_engine_model #(
    parameter int DLY = 3
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [2:0] tx_abort_req,
    output logic      [2:0] tx_abort_ack
);
    // ============================================================
    // Abort handshake
    int wait_cnt [3];
    // Drop the message some cycles after the abort shows
    always @(posedge mclk or negedge rst_n) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_n) begin
                wait_cnt[i] <= 0;
                tx_abort_ack[i] <= 1'b0;
            end else begin
                tx_abort_ack[i] <= tx_abort_req[i] && wait_cnt[i] == DLY;
                wait_cnt[i] <= (tx_abort_req[i] && wait_cnt[i] < DLY) ? wait_cnt[i] + 1 : 0;
            end
        end
    end
endmodule // cms_engine_model

// *** test/cms_status_tb_top.sv ***
// Self-checking bench for the CAN status slice
`timescale 1ns/1ps
module cms_status_tb_top;
    // ============================================================
    // Signals
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] NC  = 32'hFCFF_FFFF;
    logic mclk = 0, rst_n = 0, clk_en = 1, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]  htrans = 0, rx_arrive = 0;
    logic [2:0]  hsize = 3'h2, tx_request = 0, tx_done_ok = 0, tx_done_fail = 0;
    logic [2:0]  tx_arb_lost = 0, tx_abort_ack, tx_abort_req, err_code = 0;
    logic [28:0] tx_ident_0 = 29'h0000_0005, tx_ident_1 = 29'h0000_0007;
    logic [28:0] tx_ident_2 = 29'h0000_0009;
    logic [7:0]  rx_msg_0 = 0, rx_msg_1 = 0, rx_head_0, rx_head_1;
    logic hreadyout, hresp, err_detect = 0, xfer_clean = 0, bus_off_enter = 0;
    logic sleep_enter = 0, wake_event = 0, init_mode_active = 0;
    logic err_irq, sleep_irq, wake_irq;
    int n_fail = 0, checks_done = 0, cyc = 0, n;
    assign hready = hreadyout;
    cms_status u_cms_status (.*);
    cms_engine_model u_cms_engine_model (.*);
    always #4 mclk = ~mclk;
    // Cycle ceiling cuts a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    // ============================================================
    // Tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer, read data left in q
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q & m, e);
    endtask
    // ============================================================
    // Tests
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rdm(8'h08, ALL, 32'h1C00_0000);
        rdm(8'h0C, ALL, 32'h0000_0000);
        rdm(8'h10, ALL, 32'h0000_0000);
        rdm(8'h18, ALL, 32'h0000_0000);
        rdm(8'h40, ALL, 32'h0000_0000);
        chk({hreadyout, hresp}, 32'h0000_0002);
        xfer(1'b1, 8'h14, ALL);
        rdm(8'h14, ALL, 32'h0003_8F7F);
        $display("end reset test");
        // Two pending mailboxes, then both priority modes
        @(posedge mclk) tx_request <= 3'b100;
        @(posedge mclk) tx_request <= 3'b001;
        @(posedge mclk) tx_request <= 3'b000;
        rdm(8'h08, NC, 32'h8800_0000);
        xfer(1'b1, 8'h18, 32'h0000_0100);
        rdm(8'h08, NC, 32'h2800_0000);
        @(posedge mclk) {tx_done_ok, tx_done_fail, tx_arb_lost} <= 9'h109;
        @(posedge mclk) {tx_done_ok, tx_done_fail, tx_arb_lost} <= 9'h000;
        rdm(8'h08, NC, 32'h1C03_000D);
        xfer(1'b1, 8'h08, 32'h0000_0000);
        rdm(8'h08, NC, 32'h1C03_000D);
        xfer(1'b1, 8'h08, 32'h0003_000D);
        rdm(8'h08, NC, 32'h1C00_0000);
        xfer(1'b1, 8'h18, 32'h0000_0000);
        // Abort of a pending send
        @(posedge mclk) tx_request <= 3'b010;
        @(posedge mclk) tx_request <= 3'b000;
        xfer(1'b1, 8'h08, 32'h0000_8000);
        @(posedge mclk);
        chk(tx_abort_req, 3'b010);
        n = 0;
        while (tx_abort_req !== 3'b000 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        rdm(8'h08, ALL, 32'h1D00_0100);
        $display("end transmit test");
        // Four arrivals into a three-deep FIFO, release, clear
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) begin
                rx_arrive <= 2'b01;
                rx_msg_0 <= 8'h11 + i[7:0];
            end
        end
        @(posedge mclk) rx_arrive <= 2'b00;
        rdm(8'h0C, ALL, 32'h0000_001B);
        chk(rx_head_0, 8'h11);
        xfer(1'b1, 8'h0C, 32'h0000_0020);
        rdm(8'h0C, ALL, 32'h0000_001A);
        chk(rx_head_0, 8'h12);
        xfer(1'b1, 8'h0C, 32'h0000_0018);
        rdm(8'h0C, ALL, 32'h0000_0002);
        @(posedge mclk) {rx_arrive, rx_msg_1} <= 10'h277;
        @(posedge mclk) rx_arrive <= 2'b00;
        rdm(8'h10, ALL, 32'h0000_0001);
        chk(rx_head_1, 8'h77);
        // Arrival while the clock enable is low must be ignored
        @(posedge mclk) {clk_en, rx_arrive} <= 3'h2;
        @(posedge mclk) {clk_en, rx_arrive} <= 3'h4;
        rdm(8'h10, ALL, 32'h0000_0001);
        $display("end receive test");
        // Sleep and wake events with enables off, then on
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 8'h14, i[0] ? 32'h0003_0000 : 32'h0000_0000);
            @(posedge mclk) {sleep_enter, wake_event} <= 2'b11;
            #1;
            chk(sleep_irq, i[0]);
            chk(wake_irq, i[0]);
            @(posedge mclk) {sleep_enter, wake_event} <= 2'b00;
        end
        // Fault codes, event flag, master gate, bus-off
        xfer(1'b1, 8'h14, 32'h0000_8800);
        @(posedge mclk) {err_detect, err_code} <= 4'hB;
        @(posedge mclk) err_detect <= 1'b0;
        rdm(8'h18, ALL, 32'h0000_0034);
        chk(err_irq, 1'b1);
        @(posedge mclk) xfer_clean <= 1'b1;
        @(posedge mclk) xfer_clean <= 1'b0;
        rdm(8'h18, ALL, 32'h0000_0004);
        xfer(1'b1, 8'h14, 32'h0000_0800);
        rdm(8'h14, ALL, 32'h0000_0800);
        chk(err_irq, 1'b0);
        xfer(1'b1, 8'h18, 32'h0000_0074);
        rdm(8'h18, ALL, 32'h0000_0070);
        xfer(1'b1, 8'h14, 32'h0000_8400);
        @(posedge mclk) {err_detect, err_code} <= 4'hE;
        @(posedge mclk) err_detect <= 1'b0;
        rdm(8'h18, ALL, 32'h0000_0060);
        chk(err_irq, 1'b0);
        @(posedge mclk) bus_off_enter <= 1'b1;
        @(posedge mclk) bus_off_enter <= 1'b0;
        rdm(8'h18, ALL, 32'h0000_0064);
        chk(err_irq, 1'b1);
        @(posedge mclk) init_mode_active <= 1'b1;
        rdm(8'h18, 32'h0000_0001, 32'h0000_0001);
        $display("end interrupt test");
        conclude();
    end
endmodule // cms_status_tb_top
